// *** smx_pkg.sv ***
// Shared constants and types for the stretchable external data move unit.
package smx_pkg;
  localparam logic [7:0] SMX_ADDR_PTR0_LO = 8'h82;
  localparam logic [7:0] SMX_ADDR_PTR0_HI = 8'h83;
  localparam logic [7:0] SMX_ADDR_PTR1_LO = 8'h84;
  localparam logic [7:0] SMX_ADDR_PTR1_HI = 8'h85;
  localparam logic [7:0] SMX_ADDR_PSEL = 8'h86;
  localparam logic [7:0] SMX_ADDR_CLKCTL = 8'h8e;
  localparam logic [7:0] SMX_CLKCTL_RESET = 8'h01;
  localparam logic [15:0] SMX_PTR_RESET = 16'h0000;
  localparam logic SMX_PSEL_RESET = 1'b0;
  localparam int SMX_STRETCH_LSB = 0;
  localparam int SMX_STRETCH_MSB = 2;
  localparam int SMX_CLKS_PER_MC = 4;
  localparam logic [1:0] SMX_LAST_PHASE = 2'(SMX_CLKS_PER_MC - 1);
  localparam int SMX_INT_MCYCLES = 2;
  localparam logic [5:0] SMX_INT_LAST_CNT = 6'(SMX_INT_MCYCLES * SMX_CLKS_PER_MC - 1);
  localparam logic [3:0] SMX_EXT_BASE_MCYCLES = 4'h2;
  localparam logic [5:0] SMX_ALE_CLKS = 6'h02;
  localparam logic [5:0] SMX_STROBE_START_FAST = 6'h03;
  localparam logic [5:0] SMX_STROBE_START_SLOW = 6'h04;
  localparam logic [5:0] SMX_STROBE_LEN_FAST = 6'h02;
  localparam int SMX_SRAM_WORDS = 1024;
  localparam logic [15:0] SMX_SRAM_LAST = 16'h03ff;
  localparam logic [15:0] SMX_LOCK_STATUS_ADDR = 16'hfffc;
  localparam logic [1:0] SMX_DME_EXT_ONLY = 2'h0;
  localparam logic [1:0] SMX_DME_INT_EXT = 2'h1;
  localparam logic [1:0] SMX_DME_RESERVED = 2'h2;
  localparam logic [1:0] SMX_DME_INT_ONLY = 2'h3;
  typedef enum logic [2:0] {
    SMX_IDLE = 3'b001,
    SMX_INT = 3'b010,
    SMX_EXT = 3'b100
  } smx_state_t;
endpackage : smx_pkg

// *** smx_cycle_if.sv ***
// Machine cycle timing carried from the cycle timer to the access unit.
`timescale 1ns/1ns
`default_nettype none
interface smx_cycle_if;
  logic mc_tick;
  modport timer (output mc_tick);
  modport user (input mc_tick);
endinterface : smx_cycle_if
`default_nettype wire

// *** smx_cycle_timer.sv ***
// Machine cycle divider producing one enable pulse every four clocks.
`timescale 1ns/1ns
`default_nettype none
module smx_cycle_timer import smx_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  smx_cycle_if.timer cyc_if
);
  logic [1:0] phase_reg;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign cyc_if.mc_tick = (phase_reg == SMX_LAST_PHASE);

  property p_mc_period;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      cyc_if.mc_tick |=> !cyc_if.mc_tick [*3] ##1 cyc_if.mc_tick;
  endproperty
  a_mc_period: assert property (p_mc_period) else $error("Machine cycle is not four clocks.");
endmodule : smx_cycle_timer
`default_nettype wire

// *** smx_data_access.sv ***
// Stretchable external data move unit with dual data pointers and on-chip SRAM.
`timescale 1ns/1ns
`default_nettype none
module smx_data_access import smx_pkg::*; #(
  parameter int SRAM_WORDS = SMX_SRAM_WORDS
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic ptr_inc_in,
  input wire logic ptr_load_in,
  input wire logic [15:0] ptr_load_value_in,
  output logic [15:0] data_pointer_out,
  input wire logic data_mem_enable_hi_in,
  input wire logic data_mem_enable_lo_in,
  input wire logic [2:0] lock_status_in,
  input wire logic xmove_req_in,
  input wire logic xmove_write_in,
  input wire logic xmove_use_ptr_in,
  input wire logic [15:0] xmove_addr_in,
  input wire logic [7:0] xmove_wdata_in,
  output logic xmove_accept_out,
  output logic xmove_busy_out,
  output logic xmove_done_out,
  output logic [7:0] xmove_rdata_out,
  input wire logic [7:0] low_addr_data_port_in,
  output logic [7:0] low_addr_data_port_out,
  output logic low_addr_data_port_oe_out,
  output logic [7:0] high_addr_port_out,
  output logic high_addr_port_oe_out,
  output logic addr_latch_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out
);
  smx_cycle_if cyc_if ();

  smx_cycle_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .cyc_if(cyc_if.timer)
  );

  logic [7:0] clkctl_reg;
  logic [2:0] stretch;
  logic [15:0] ptr0_reg;
  logic [15:0] ptr1_reg;
  logic psel_reg;
  logic [15:0] sel_ptr;
  logic [1:0] dme;
  logic [15:0] req_addr;
  logic req_in_sram;
  logic req_ext;
  smx_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [5:0] last_cnt;
  logic [5:0] strobe_start;
  logic [5:0] strobe_len;
  logic [2:0] acc_stretch_reg;
  logic [15:0] acc_addr_reg;
  logic acc_write_reg;
  logic acc_sram_reg;
  logic acc_ext_reg;
  logic [7:0] acc_wdata_reg;
  logic [7:0] sram_mem [SRAM_WORDS];
  logic [7:0] p0_s1_reg;
  logic [7:0] p0_s2_reg;
  logic [7:0] p0_s3_reg;
  logic [7:0] p0_filt_reg;
  logic [7:0] p0_sync;
  logic in_strobe;

  assign stretch = clkctl_reg[SMX_STRETCH_MSB:SMX_STRETCH_LSB];
  assign dme = {data_mem_enable_hi_in, data_mem_enable_lo_in};
  assign sel_ptr = psel_reg ? ptr1_reg : ptr0_reg;
  assign data_pointer_out = sel_ptr;

  // Clock control: the whole byte is stored, only the low three bits steer timing.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clkctl_reg <= SMX_CLKCTL_RESET;
    end else if (sfr_wr_in && sfr_addr_in == SMX_ADDR_CLKCTL) begin
      clkctl_reg <= sfr_wdata_in;
    end
  end

  // Pointer load and increment come from the core and win over a byte write.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ptr0_reg <= SMX_PTR_RESET;
      ptr1_reg <= SMX_PTR_RESET;
    end else if (ptr_load_in) begin
      if (psel_reg) begin
        ptr1_reg <= ptr_load_value_in;
      end else begin
        ptr0_reg <= ptr_load_value_in;
      end
    end else if (ptr_inc_in) begin
      if (psel_reg) begin
        ptr1_reg <= ptr1_reg + 16'h0001;
      end else begin
        ptr0_reg <= ptr0_reg + 16'h0001;
      end
    end else if (sfr_wr_in) begin
      unique case (sfr_addr_in)
        SMX_ADDR_PTR0_LO: ptr0_reg[7:0] <= sfr_wdata_in;
        SMX_ADDR_PTR0_HI: ptr0_reg[15:8] <= sfr_wdata_in;
        SMX_ADDR_PTR1_LO: ptr1_reg[7:0] <= sfr_wdata_in;
        SMX_ADDR_PTR1_HI: ptr1_reg[15:8] <= sfr_wdata_in;
        default: ;
      endcase
    end
  end

  // Only the lsb is kept, so an increment of the register flips the selection.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      psel_reg <= SMX_PSEL_RESET;
    end else if (sfr_wr_in && sfr_addr_in == SMX_ADDR_PSEL) begin
      psel_reg <= sfr_wdata_in[0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        SMX_ADDR_PTR0_LO: sfr_rdata_out <= ptr0_reg[7:0];
        SMX_ADDR_PTR0_HI: sfr_rdata_out <= ptr0_reg[15:8];
        SMX_ADDR_PTR1_LO: sfr_rdata_out <= ptr1_reg[7:0];
        SMX_ADDR_PTR1_HI: sfr_rdata_out <= ptr1_reg[15:8];
        SMX_ADDR_PSEL: sfr_rdata_out <= {7'h00, psel_reg};
        SMX_ADDR_CLKCTL: sfr_rdata_out <= clkctl_reg;
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  // Target decode. The reserved enable code is treated as fully external.
  assign req_addr = xmove_use_ptr_in ? sel_ptr : xmove_addr_in;
  assign req_in_sram = (dme == SMX_DME_INT_EXT || dme == SMX_DME_INT_ONLY) &&
                       (req_addr <= SMX_SRAM_LAST);
  assign req_ext = (dme == SMX_DME_EXT_ONLY) || (dme == SMX_DME_RESERVED) ||
                   (dme == SMX_DME_INT_EXT && req_addr > SMX_SRAM_LAST);
  assign xmove_accept_out = (state_reg == SMX_IDLE) && xmove_req_in && cyc_if.mc_tick;
  assign xmove_busy_out = (state_reg != SMX_IDLE);

  // Stretch is sampled at acceptance, so a new setting applies from the next move on.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_stretch_reg <= SMX_CLKCTL_RESET[2:0];
      acc_addr_reg <= 16'h0000;
      acc_write_reg <= 1'b0;
      acc_sram_reg <= 1'b0;
      acc_ext_reg <= 1'b0;
      acc_wdata_reg <= 8'h00;
    end else if (xmove_accept_out) begin
      acc_stretch_reg <= stretch;
      acc_addr_reg <= req_addr;
      acc_write_reg <= xmove_write_in;
      acc_sram_reg <= req_in_sram;
      acc_ext_reg <= req_ext;
      acc_wdata_reg <= xmove_wdata_in;
    end
  end

  // Only data moves are timed here; instruction fetch never sees the stretch.
  assign last_cnt = acc_ext_reg ? {{1'b0, acc_stretch_reg} + SMX_EXT_BASE_MCYCLES, 2'b00}
                                  - 6'h01 : SMX_INT_LAST_CNT;
  assign strobe_start = (acc_stretch_reg == 3'h0) ? SMX_STROBE_START_FAST
                                                  : SMX_STROBE_START_SLOW;
  assign strobe_len = (acc_stretch_reg == 3'h0) ? SMX_STROBE_LEN_FAST
                                                : {1'b0, acc_stretch_reg, 2'b00};

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= SMX_IDLE;
      cnt_reg <= 6'h00;
    end else begin
      unique case (state_reg)
        SMX_IDLE: begin
          cnt_reg <= 6'h00;
          if (xmove_accept_out) begin
            state_reg <= req_ext ? SMX_EXT : SMX_INT;
          end
        end
        SMX_INT, SMX_EXT: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == last_cnt) begin
            state_reg <= SMX_IDLE;
          end
        end
        default: state_reg <= SMX_IDLE;
      endcase
    end
  end

  // Pad input passes three flops; a bit changes only when stages two and three agree.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p0_s1_reg <= 8'h00;
      p0_s2_reg <= 8'h00;
      p0_s3_reg <= 8'h00;
      p0_filt_reg <= 8'h00;
    end else begin
      p0_s1_reg <= low_addr_data_port_in;
      p0_s2_reg <= p0_s1_reg;
      p0_s3_reg <= p0_s2_reg;
      p0_filt_reg <= p0_sync;
    end
  end

  // The agreed value is used directly, so a zero-stretch read needs no fourth stage.
  assign p0_sync = (p0_s2_reg & p0_s3_reg) | (p0_filt_reg & (p0_s2_reg ^ p0_s3_reg));

  // The SRAM keeps no reset; its contents survive changes of the enable bits.
  always_ff @(posedge clk_sys_in) begin
    if (state_reg == SMX_INT && cnt_reg == last_cnt && acc_sram_reg && acc_write_reg) begin
      sram_mem[acc_addr_reg[9:0]] <= acc_wdata_reg;
    end
  end

  // Read data is taken at the last clock, so the part must hold it through the hold phase.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xmove_done_out <= 1'b0;
      xmove_rdata_out <= 8'h00;
    end else begin
      xmove_done_out <= xmove_busy_out && (cnt_reg == last_cnt);
      if (xmove_busy_out && cnt_reg == last_cnt && !acc_write_reg) begin
        if (acc_ext_reg) begin
          xmove_rdata_out <= p0_sync;
        end else if (acc_sram_reg) begin
          xmove_rdata_out <= sram_mem[acc_addr_reg[9:0]];
        end else if (acc_addr_reg == SMX_LOCK_STATUS_ADDR) begin
          xmove_rdata_out <= {5'h00, lock_status_in};
        end else begin
          xmove_rdata_out <= 8'h00;
        end
      end
    end
  end

  assign in_strobe = (cnt_reg >= strobe_start) && (cnt_reg < strobe_start + strobe_len);

  // Bus pins are registered, so each pin phase shows one clock after its count.
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_addr_data_port_out <= 8'h00;
      low_addr_data_port_oe_out <= 1'b0;
      high_addr_port_out <= 8'h00;
      high_addr_port_oe_out <= 1'b0;
      addr_latch_out <= 1'b0;
      read_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
    end else if (state_reg == SMX_EXT) begin
      high_addr_port_out <= acc_addr_reg[15:8];
      high_addr_port_oe_out <= 1'b1;
      addr_latch_out <= (cnt_reg < SMX_ALE_CLKS);
      if (cnt_reg <= SMX_ALE_CLKS) begin
        low_addr_data_port_out <= acc_addr_reg[7:0];
        low_addr_data_port_oe_out <= 1'b1;
      end else begin
        low_addr_data_port_out <= acc_wdata_reg;
        low_addr_data_port_oe_out <= acc_write_reg;
      end
      read_strobe_n_out <= !(in_strobe && !acc_write_reg);
      write_strobe_n_out <= !(in_strobe && acc_write_reg);
    end else begin
      low_addr_data_port_oe_out <= 1'b0;
      high_addr_port_oe_out <= 1'b0;
      addr_latch_out <= 1'b0;
      read_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
    end
  end

  // Helper counters watched only by the checks below.
  logic strobe_on;
  logic [5:0] h_busy_cnt;
  logic [5:0] h_strobe_cnt;
  logic [5:0] h_frame_cnt;
  logic h_clkctl_written;
  assign strobe_on = !read_strobe_n_out || !write_strobe_n_out;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      h_busy_cnt <= 6'h00;
      h_strobe_cnt <= 6'h00;
      h_frame_cnt <= 6'h00;
      h_clkctl_written <= 1'b0;
    end else begin
      h_busy_cnt <= xmove_busy_out ? h_busy_cnt + 6'h01 : 6'h00;
      h_strobe_cnt <= strobe_on ? h_strobe_cnt + 6'h01 : 6'h00;
      h_frame_cnt <= high_addr_port_oe_out ? h_frame_cnt + 6'h01 : 6'h00;
      if (sfr_wr_in && sfr_addr_in == SMX_ADDR_CLKCTL) begin
        h_clkctl_written <= 1'b1;
      end
    end
  end

  property p_int_two_cycles;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (xmove_accept_out && !req_ext) |-> ##9 xmove_done_out;
  endproperty
  a_int_two_cycles: assert property (p_int_two_cycles) else $error("On-chip move not 8 clocks.");

  property p_stretch_write;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (sfr_wr_in && sfr_addr_in == SMX_ADDR_CLKCTL) |=> stretch == $past(sfr_wdata_in[2:0]);
  endproperty
  a_stretch_write: assert property (p_stretch_write) else $error("Stretch write not stored.");

  property p_ext_length;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (xmove_done_out && acc_ext_reg) |-> h_busy_cnt == {{1'b0, acc_stretch_reg} + 4'h2, 2'b00};
  endproperty
  a_ext_length: assert property (p_ext_length) else $error("Off-chip move length wrong.");

  property p_strobe_width;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      $fell(strobe_on) |-> h_strobe_cnt == ((acc_stretch_reg == 3'h0) ? 6'h02
                                             : {1'b0, acc_stretch_reg, 2'b00});
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("Strobe width wrong.");

  property p_reset_stretch;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      !h_clkctl_written |-> stretch == 3'h1;
  endproperty
  a_reset_stretch: assert property (p_reset_stretch) else $error("Stretch not one after reset.");

  property p_setup_extra;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(strobe_on) |-> h_frame_cnt == ((acc_stretch_reg == 3'h0) ? 6'h03 : 6'h04);
  endproperty
  a_setup_extra: assert property (p_setup_extra) else $error("Strobe setup clocks wrong.");

  property p_stretch_sampled;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      xmove_accept_out |=> acc_stretch_reg == $past(stretch);
  endproperty
  a_stretch_sampled: assert property (p_stretch_sampled) else $error("Move ignored new stretch.");

  property p_psel_zero;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (sfr_rd_in && sfr_addr_in == SMX_ADDR_PSEL) |=> sfr_rdata_out[7:1] == 7'h00;
  endproperty
  a_psel_zero: assert property (p_psel_zero) else $error("Select upper bits not zero.");

  property p_inc_selected;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (ptr_inc_in && !ptr_load_in && psel_reg) |=>
        ptr1_reg == $past(ptr1_reg) + 16'h0001 && ptr0_reg == $past(ptr0_reg);
  endproperty
  a_inc_selected: assert property (p_inc_selected) else $error("Wrong pointer incremented.");

  property p_sram_target;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (xmove_accept_out && dme == SMX_DME_INT_EXT && req_addr <= SMX_SRAM_LAST) |=>
        state_reg == SMX_INT ##1 !high_addr_port_oe_out [*8];
  endproperty
  a_sram_target: assert property (p_sram_target) else $error("SRAM move reached the bus.");

  property p_all_external;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (xmove_accept_out && dme == SMX_DME_EXT_ONLY) |-> ##2 high_addr_port_oe_out && addr_latch_out;
  endproperty
  a_all_external: assert property (p_all_external) else $error("Move did not go off-chip.");
endmodule : smx_data_access
`default_nettype wire

// *** smx_ext_mem.sv ***
// Behavioural external memory on the multiplexed low address and data bus.
`timescale 1ns/1ns
`default_nettype none
module smx_ext_mem #(
  parameter int RESP_DELAY = 0,
  parameter logic [7:0] BLANK = 8'hee
) (
  input wire logic clk_in,
  input wire logic [7:0] low_port_in,
  input wire logic [7:0] high_port_in,
  input wire logic high_oe_in,
  input wire logic latch_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  output logic [7:0] bus_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] low_addr_reg = 8'h00;
  logic [15:0] last_addr = 16'h0000;
  logic [7:0] drive_reg = 8'h00;
  logic driving_reg = 1'b0;
  int wait_cnt = 0;
  logic [15:0] rd_addr;
  logic answer;
  initial begin
    foreach (mem[i]) mem[i] = BLANK;
  end
  assign rd_addr = {high_port_in, low_addr_reg};
  assign answer = !read_n_in && wait_cnt >= RESP_DELAY;
  // A released bus shows the inverse of the last byte, so stale data never passes for good data.
  assign bus_out = answer ? mem[rd_addr] : (driving_reg ? drive_reg : ~drive_reg);
  always @(posedge clk_in) begin
    if (latch_in) begin
      low_addr_reg <= low_port_in;
    end
  end
  always @(posedge clk_in) begin
    if (!write_n_in) begin
      mem[rd_addr] <= low_port_in;
      last_addr <= rd_addr;
    end
    if (!read_n_in) begin
      wait_cnt <= wait_cnt + 1;
      last_addr <= rd_addr;
    end else begin
      wait_cnt <= 0;
    end
    if (answer) begin
      driving_reg <= 1'b1;
      drive_reg <= mem[rd_addr];
    end else if (read_n_in && !high_oe_in) begin
      driving_reg <= 1'b0;
    end
  end
endmodule : smx_ext_mem
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the stretchable external data move unit.
`timescale 1ns/1ns
`default_nettype none
`define check_eq(what, exp, got) begin checks++; if ((exp) !== (got)) begin miscompares++; $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module testbench;
  import smx_pkg::*;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] sa, swd, srd, p0_out, p0_mem, p0_pad, p2_out, rdata, xrd, mwd, d;
  logic sw, sr, pinc, pld, dhi, dlo, req, wr, up, acc, busy, done, p0_oe, p2_oe, ale, rdn, wrn;
  logic [15:0] ldv, data_pointer, ma;
  logic [2:0] lock;
  int miscompares = 0;
  int checks = 0;
  int ncyc, nstb;
  always #4 clk_sys_in = ~clk_sys_in;
  assign p0_pad = p0_oe ? p0_out : p0_mem;
  smx_data_access dut_u (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sfr_addr_in(sa),
    .sfr_wr_in(sw), .sfr_rd_in(sr), .sfr_wdata_in(swd), .sfr_rdata_out(srd), .ptr_inc_in(pinc),
    .ptr_load_in(pld), .ptr_load_value_in(ldv), .data_pointer_out(data_pointer),
    .data_mem_enable_hi_in(dhi), .data_mem_enable_lo_in(dlo), .lock_status_in(lock),
    .xmove_req_in(req), .xmove_write_in(wr), .xmove_use_ptr_in(up), .xmove_addr_in(ma),
    .xmove_wdata_in(mwd), .xmove_accept_out(acc), .xmove_busy_out(busy),
    .xmove_done_out(done), .xmove_rdata_out(xrd), .low_addr_data_port_in(p0_pad),
    .low_addr_data_port_out(p0_out), .low_addr_data_port_oe_out(p0_oe),
    .high_addr_port_out(p2_out), .high_addr_port_oe_out(p2_oe), .addr_latch_out(ale),
    .read_strobe_n_out(rdn), .write_strobe_n_out(wrn));
  smx_ext_mem mem_u (.clk_in(clk_sys_in), .low_port_in(p0_out), .high_port_in(p2_out),
    .high_oe_in(p2_oe), .latch_in(ale), .read_n_in(rdn), .write_n_in(wrn), .bus_out(p0_mem));
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    sa <= a;
    swd <= v;
    sw <= 1'b1;
    @(posedge clk_sys_in);
    sw <= 1'b0;
    @(negedge clk_sys_in);
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    sa <= a;
    sr <= 1'b1;
    @(posedge clk_sys_in);
    sr <= 1'b0;
    @(negedge clk_sys_in);
    v = srd;
  endtask : sfr_read
  task automatic ptr_op(input logic inc, input logic ld, input logic [15:0] v);
    @(posedge clk_sys_in);
    pinc <= inc;
    pld <= ld;
    ldv <= v;
    @(posedge clk_sys_in);
    pinc <= 1'b0;
    pld <= 1'b0;
    @(negedge clk_sys_in);
  endtask : ptr_op
  // The request is held until an edge that takes it, since off-tick requests only wait.
  task automatic run_move(input logic w, input logic u, input logic [15:0] a,
                          input logic [7:0] wd, input int s, input logic ext);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    req <= 1'b1;
    wr <= w;
    up <= u;
    ma <= a;
    mwd <= wd;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (acc !== 1'b1 && n < 20);
    @(posedge clk_sys_in);
    req <= 1'b0;
    ncyc = 0;
    nstb = 0;
    while (done !== 1'b1 && ncyc < 60) begin
      @(negedge clk_sys_in);
      ncyc++;
      if (rdn === 1'b0 || wrn === 1'b0) nstb++;
    end
    `check_eq("move cycles", ext ? 1 + 4 * (s + 2) : 9, ncyc)
    `check_eq("strobe clocks", !ext ? 0 : (s == 0 ? 2 : 4 * s), nstb)
    `check_eq("busy at done", 1'b0, busy)
    rdata = xrd;
  endtask : run_move
  initial begin
    repeat (6000) @(posedge clk_sys_in);
    miscompares++;
    stop_test();
  end
  initial begin
    {sa, swd, sw, sr, pinc, pld, ldv, dhi, dlo, lock, req, wr, up, ma, mwd} = '0;
    repeat (8) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    sfr_read(SMX_ADDR_CLKCTL, d); `check_eq("clock_control", 8'h01, d)
    sfr_read(SMX_ADDR_PSEL, d); `check_eq("pointer_select", 8'h00, d)
    sfr_read(8'h90, d); `check_eq("unmapped", 8'h00, d)
    run_move(1'b1, 1'b0, 16'h2345, 8'ha5, 1, 1'b1);
    run_move(1'b0, 1'b0, 16'h2345, 8'h00, 1, 1'b1);
    `check_eq("default read", 8'ha5, rdata)
    for (int s = 0; s < 8; s++) begin
      sfr_write(SMX_ADDR_CLKCTL, 8'(s));
      sfr_read(SMX_ADDR_CLKCTL, d); `check_eq("stretch", 8'(s), d)
      run_move(1'b1, 1'b0, 16'h4a00 + 16'(s), 8'h3c ^ 8'(s), s, 1'b1);
      `check_eq("write addr", 16'h4a00 + 16'(s), mem_u.last_addr)
      run_move(1'b0, 1'b0, 16'h4a00 + 16'(s), 8'h00, s, 1'b1);
      `check_eq("ext read", 8'h3c ^ 8'(s), rdata)
    end
    sfr_write(SMX_ADDR_PTR0_LO, 8'h34);
    sfr_write(SMX_ADDR_PTR0_HI, 8'h12);
    sfr_write(SMX_ADDR_PTR1_LO, 8'hff);
    sfr_write(SMX_ADDR_PTR1_HI, 8'h56);
    `check_eq("pointer0", 16'h1234, data_pointer)
    sfr_write(SMX_ADDR_PSEL, 8'hff);
    sfr_read(SMX_ADDR_PSEL, d); `check_eq("select", 8'h01, d)
    `check_eq("pointer1", 16'h56ff, data_pointer)
    ptr_op(1'b1, 1'b0, 16'h0000); `check_eq("inc", 16'h5700, data_pointer)
    sfr_read(SMX_ADDR_PTR1_HI, d); `check_eq("pointer1 high", 8'h57, d)
    sfr_write(SMX_ADDR_PSEL, d - 8'h56 + 8'h01); `check_eq("toggled", 16'h1234, data_pointer)
    ptr_op(1'b0, 1'b1, 16'h4b10); `check_eq("load", 16'h4b10, data_pointer)
    run_move(1'b1, 1'b1, 16'h0000, 8'h77, 7, 1'b1);
    `check_eq("pointer addr", 16'h4b10, mem_u.last_addr)
    @(posedge clk_sys_in);
    dlo <= 1'b1;
    run_move(1'b1, 1'b0, 16'h0010, 8'h9e, 7, 1'b0);
    run_move(1'b0, 1'b0, 16'h0010, 8'h00, 7, 1'b0);
    `check_eq("sram read", 8'h9e, rdata)
    run_move(1'b0, 1'b0, 16'h0400, 8'h00, 7, 1'b1);
    @(posedge clk_sys_in);
    dlo <= 1'b0;
    run_move(1'b0, 1'b0, 16'h0010, 8'h00, 7, 1'b1);
    `check_eq("ext blank", mem_u.BLANK, rdata)
    @(posedge clk_sys_in);
    dlo <= 1'b1;
    dhi <= 1'b1;
    lock <= 3'b101;
    run_move(1'b0, 1'b0, SMX_LOCK_STATUS_ADDR, 8'h00, 7, 1'b0);
    `check_eq("lock status", 8'h05, rdata)
    stop_test();
  end
endmodule : testbench
`default_nettype wire
